// ---- core/seq_regs.svh ----
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// clock period of the sequencing logic
`define CLK_PERIOD_NS 40
// power-good assertion delay after the output reaches its upper threshold
`define OK_RISE_DLY_NS 450000
// power-good de-glitch delay after the output falls below its lower threshold
`define OK_FALL_DLY_NS 80000
// longest start-up delay and the number of equal steps to reach it
`define START_DLY_MAX_NS 10000000
`define START_DLY_STEPS 7
// width of every delay counter
`define TMR_W 20
// reset values of the sequencer state
`define OK_IND_INIT 1'b0
`define CFG_RST_INIT 1'b1

`endif

// ---- core/seq_pkg.sv ----
package seq_pkg;

  // power delivery sequence, one-hot
  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_DELAY  = 3'b010,
    ST_ACTIVE = 3'b100
  } seq_state_t;

  // complete registered state of the sequencer
  typedef struct packed {
    seq_state_t state;
    logic ok_ind;
    logic drv_lvl;
    logic hs_on;
    logic ls_on;
    logic deliver;
    logic ss_start;
    logic cfg_rst;
  } seq_st_t;

endpackage

// ---- core/seq_timer_if.sv ----
interface seq_timer_if #(
  parameter int W = 20
);
  logic clr;
  logic run;
  logic [W-1:0] limit;
  logic done;

  modport ctrl (output clr, output run, output limit, input done);
  modport tmr (input clr, input run, input limit, output done);
endinterface

// ---- core/seq_sync.sv ----
module seq_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // raw comparator levels and their synchronised copies
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;

endmodule

// ---- core/seq_timer.sv ----
module seq_timer #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // control and expiry
  seq_timer_if.tmr tmr
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_st_t;

  tmr_st_t st_ff;
  tmr_st_t nxt_st;

  // count up and hold at the limit; a clear always restarts from zero
  always_comb begin
    nxt_st = st_ff;
    if (tmr.clr) begin
      nxt_st.cnt = '0;
    end else if (tmr.run && (st_ff.cnt != tmr.limit)) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // expiry is masked by a clear in the same cycle
  assign tmr.done = !tmr.clr && (st_ff.cnt == tmr.limit);

endmodule

// ---- core/power_good_enable_sequencer.sv ----
`include "seq_regs.svh"

module power_good_enable_sequencer #(
  parameter int OK_RISE_CYC = `OK_RISE_DLY_NS / `CLK_PERIOD_NS,
  parameter int OK_FALL_CYC = `OK_FALL_DLY_NS / `CLK_PERIOD_NS,
  parameter int START_STEP_CYC =
    `START_DLY_MAX_NS / (`CLK_PERIOD_NS * `START_DLY_STEPS)
) (
  // clock and supply lockout reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // comparators and fault levels
  input wire logic en_cmp_i,
  input wire logic out_ok_cmp_i,
  input wire logic out_low_cmp_i,
  input wire logic therm_sd_i,
  // modulator inputs
  input wire logic osc_tick_i,
  input wire logic ls_below_ref_i,
  // configuration
  input wire logic [2:0] start_dly_code_i,
  // open-drain power-good pin
  output logic output_ok_indicator_o,
  output logic output_ok_indicator_oe_n_o,
  // power stage
  output logic hs_gate_o,
  output logic ls_gate_o,
  output logic deliver_o,
  output logic soft_start_o,
  // reset towards the serial interface and registers
  output logic cfg_rst_o
);

  localparam seq_pkg::seq_st_t ST_RST = '{
    state: seq_pkg::ST_OFF,
    ok_ind: `OK_IND_INIT,
    drv_lvl: 1'b0,
    hs_on: 1'b0,
    ls_on: 1'b0,
    deliver: 1'b0,
    ss_start: 1'b0,
    cfg_rst: `CFG_RST_INIT
  };

  seq_pkg::seq_st_t st_ff;
  seq_pkg::seq_st_t nxt_st;

  logic [3:0] raw_lvl;
  logic [3:0] syn_lvl;
  logic en_s;
  logic ok_s;
  logic low_s;
  logic therm_s;
  logic kill;

  // comparators come from the analog side; two flops before any use
  assign raw_lvl = {therm_sd_i, out_low_cmp_i, out_ok_cmp_i, en_cmp_i};

  seq_sync #(.W(4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i(raw_lvl),
    .q_o(syn_lvl)
  );

  assign en_s = syn_lvl[0];
  assign ok_s = syn_lvl[1];
  assign low_s = syn_lvl[2];
  assign therm_s = syn_lvl[3];

  // conditions that drop the indicator with no delay
  assign kill = !en_s || therm_s;

  seq_timer_if #(.W(`TMR_W)) rise_if ();
  seq_timer_if #(.W(`TMR_W)) fall_if ();
  seq_timer_if #(.W(`TMR_W)) dly_if ();

  // assertion delay restarts on any dip below the upper threshold
  assign rise_if.clr = !ok_s || kill || st_ff.ok_ind;
  assign rise_if.run = 1'b1;
  assign rise_if.limit = `TMR_W'(OK_RISE_CYC);

  // de-glitch restarts whenever the output is back above 90%
  assign fall_if.clr = !low_s || kill || !st_ff.ok_ind;
  assign fall_if.run = 1'b1;
  assign fall_if.limit = `TMR_W'(OK_FALL_CYC);

  // start-up delay runs only while waiting in the delay state
  assign dly_if.clr = (st_ff.state != seq_pkg::ST_DELAY);
  assign dly_if.run = 1'b1;
  assign dly_if.limit =
    `TMR_W'(32'(start_dly_code_i) * START_STEP_CYC);

  seq_timer #(.W(`TMR_W)) u_rise (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tmr(rise_if.tmr)
  );

  seq_timer #(.W(`TMR_W)) u_fall (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tmr(fall_if.tmr)
  );

  seq_timer #(.W(`TMR_W)) u_dly (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tmr(dly_if.tmr)
  );

  // sequence, indicator and switch timing
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ss_start = 1'b0;
    nxt_st.drv_lvl = 1'b0;
    // asserted only by the lockout reset, never by enable
    nxt_st.cfg_rst = 1'b0;
    unique case (st_ff.state)
      seq_pkg::ST_OFF: begin
        if (en_s) begin
          nxt_st.state = seq_pkg::ST_DELAY;
        end
      end
      seq_pkg::ST_DELAY: begin
        if (!en_s) begin
          nxt_st.state = seq_pkg::ST_OFF;
        end else if (dly_if.done) begin
          nxt_st.state = seq_pkg::ST_ACTIVE;
          nxt_st.ss_start = 1'b1;
        end
      end
      seq_pkg::ST_ACTIVE: begin
        if (!en_s) begin
          nxt_st.state = seq_pkg::ST_OFF;
        end
      end
      default: begin
        nxt_st.state = seq_pkg::ST_OFF;
      end
    endcase
    // thermal shutdown blocks the power stage but leaves the sequence state unchanged
    nxt_st.deliver = (nxt_st.state == seq_pkg::ST_ACTIVE) && !therm_s;
    // clock edge wins over the valley comparator in the same cycle
    if (!nxt_st.deliver) begin
      nxt_st.hs_on = 1'b0;
    end else if (osc_tick_i) begin
      nxt_st.hs_on = 1'b0;
    end else if (ls_below_ref_i) begin
      nxt_st.hs_on = 1'b1;
    end
    nxt_st.ls_on = nxt_st.deliver && !nxt_st.hs_on;
    // power-good indicator
    if (kill) begin
      nxt_st.ok_ind = 1'b0;
    end else if (!st_ff.ok_ind && rise_if.done) begin
      nxt_st.ok_ind = 1'b1;
    end else if (st_ff.ok_ind && fall_if.done) begin
      nxt_st.ok_ind = 1'b0;
    end
  end

  // lockout reset forces the whole state, indicator low at once
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output straight from the state register
  assign output_ok_indicator_o = st_ff.drv_lvl;
  assign output_ok_indicator_oe_n_o = st_ff.ok_ind;
  assign hs_gate_o = st_ff.hs_on;
  assign ls_gate_o = st_ff.ls_on;
  assign deliver_o = st_ff.deliver;
  assign soft_start_o = st_ff.ss_start;
  assign cfg_rst_o = st_ff.cfg_rst;

  // run-length counters watched by the delay checks
  logic [`TMR_W-1:0] rise_len_ff;
  logic [`TMR_W-1:0] fall_len_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || rise_if.clr) begin
      rise_len_ff <= '0;
    end else begin
      rise_len_ff <= rise_len_ff + 1'b1;
    end
    if (srst_i || fall_if.clr) begin
      fall_len_ff <= '0;
    end else begin
      fall_len_ff <= fall_len_ff + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_lockout_cfg_rst: assert property (
    disable iff (1'b0) 1'b1 |=> (cfg_rst_o == $past(srst_i)))
    else $error("interface reset does not follow lockout");

  a_en_keeps_cfg: assert property (
    (!en_s && !srst_i) |=> !cfg_rst_o [*2])
    else $error("enable low reset the configuration");

  a_en_stops_power: assert property (
    !en_s |=> (!deliver_o && !hs_gate_o && !ls_gate_o))
    else $error("power delivered while enable low");

  a_rise_delay: assert property (
    $rose(output_ok_indicator_oe_n_o) |->
      (rise_len_ff == `TMR_W'(OK_RISE_CYC + 1)))
    else $error("power-good rose at the wrong time");

  a_rise_restart: assert property (
    (!ok_s && !output_ok_indicator_oe_n_o) |=> ##1 (rise_len_ff <= 1))
    else $error("assertion delay not restarted");

  a_fall_deglitch: assert property (
    ($fell(output_ok_indicator_oe_n_o) && !$past(kill)) |->
      (fall_len_ff == `TMR_W'(OK_FALL_CYC + 1)))
    else $error("power-good fell without full de-glitch");

  a_en_drops_ok: assert property (
    !en_s |=> !output_ok_indicator_oe_n_o)
    else $error("power-good held while enable low");

  a_fault_drops_ok: assert property (
    disable iff (1'b0) (srst_i || (therm_s && !srst_i)) |=>
      (!output_ok_indicator_oe_n_o && !output_ok_indicator_o))
    else $error("power-good held during a fault");

  a_tick_hs_off: assert property (
    osc_tick_i |=> !hs_gate_o)
    else $error("high-side on after clock edge");

  a_valley_hs_on: assert property (
    (deliver_o && !hs_gate_o && ls_below_ref_i && !osc_tick_i && en_s &&
      !therm_s) |=> (hs_gate_o && !ls_gate_o))
    else $error("high-side not turned on at valley");

  a_ss_after_dly: assert property (
    $rose(soft_start_o) |->
      ($past(st_ff.state) == seq_pkg::ST_DELAY) && $past(dly_if.done) ##1
      !soft_start_o)
    else $error("soft-start without expired delay");

  a_therm_stage_off: assert property (
    therm_s |=> (!deliver_o && !hs_gate_o && !ls_gate_o && !cfg_rst_o))
    else $error("thermal shutdown handled wrongly");

  // released pin means good, so the active-low enable rising is the good edge
  c_ok_rise: cover property ($rose(output_ok_indicator_oe_n_o));
  c_ok_fall: cover property (
    $fell(output_ok_indicator_oe_n_o) && !$past(kill));
  c_soft_start: cover property (soft_start_o);
  c_valley_cycle: cover property (hs_gate_o ##1 !hs_gate_o ##[1:20] hs_gate_o);

endmodule

// ---- sim/rail_model.sv ----
// regulated output rail as seen by the two threshold comparators
module rail_model #(
  parameter int RAMP = 6
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // stimulus from the power stage and the bench
  input wire logic deliver_i,
  input wire logic dip_i,
  // comparator levels
  output logic out_ok_o,
  output logic out_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp_cnt;

  // output ramps up while delivering, collapses at once when not
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !deliver_i) begin
      ramp_cnt <= 0;
      out_ok_o <= 1'b0;
      out_low_o <= 1'b1;
    end else begin
      if (ramp_cnt < RAMP) ramp_cnt <= ramp_cnt + 1;
      out_ok_o <= (ramp_cnt == RAMP) && !dip_i;
      out_low_o <= (ramp_cnt < RAMP) || dip_i;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 0;
  localparam int PGH = 1;
  localparam int PGL = 2;
  localparam int OKR = 3;
  typedef struct {logic [2:0] code; int cyc;} row_t;
  // 4 cycles of sync and entry plus code times a step of 4
  row_t rows[8] = '{'{3'h0, 4}, '{3'h1, 8}, '{3'h2, 12}, '{3'h3, 16},
    '{3'h4, 20}, '{3'h5, 24}, '{3'h6, 28}, '{3'h7, 32}};
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic en_cmp_i = 1'b0;
  logic therm_sd_i = 1'b0;
  logic osc_tick_i = 1'b0;
  logic ls_below_ref_i = 1'b0;
  logic dip = 1'b0;
  logic [2:0] start_dly_code_i = 3'h0;
  logic out_ok_cmp_i, out_low_cmp_i, output_ok_indicator_o;
  logic output_ok_indicator_oe_n_o, hs_gate_o, ls_gate_o;
  logic deliver_o, soft_start_o, cfg_rst_o, ind_pin;
  int fails = 0;
  int checked = 0;
  int n;

  // open-drain pin with its external pull-up
  assign ind_pin = output_ok_indicator_oe_n_o ? 1'b1 : output_ok_indicator_o;

  always #20 sys_clk_i = ~sys_clk_i;

  power_good_enable_sequencer #(
    .OK_RISE_CYC(8), .OK_FALL_CYC(5), .START_STEP_CYC(4)
  ) dut_u (
    .sys_clk_i, .srst_i, .en_cmp_i, .out_ok_cmp_i, .out_low_cmp_i,
    .therm_sd_i, .osc_tick_i, .ls_below_ref_i, .start_dly_code_i,
    .output_ok_indicator_o, .output_ok_indicator_oe_n_o, .hs_gate_o,
    .ls_gate_o, .deliver_o, .soft_start_o, .cfg_rst_o
  );

  rail_model rail_u (
    .sys_clk_i, .srst_i, .deliver_i(deliver_o), .dip_i(dip),
    .out_ok_o(out_ok_cmp_i), .out_low_o(out_low_cmp_i)
  );

  function automatic logic probe(int sel);
    case (sel)
      SS: return soft_start_o === 1'b1;
      PGH: return ind_pin === 1'b1;
      PGL: return ind_pin === 1'b0;
      default: return out_ok_cmp_i === 1'b1;
    endcase
  endfunction

  // edges until the probe holds, capped so a dead output cannot hang
  task automatic wait_cyc(input int sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end while (!probe(sel) && cnt < lim);
  endtask

  task automatic chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle modulator stimulus, result visible after the next edge
  task automatic mod_step(input logic t, input logic b);
    @(posedge sys_clk_i);
    osc_tick_i <= t;
    ls_below_ref_i <= b;
    @(posedge sys_clk_i);
    osc_tick_i <= 1'b0;
    ls_below_ref_i <= 1'b0;
    #1;
  endtask

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    #(40 * 5000);
    fails++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk_b(cfg_rst_o, 1'b0);
    foreach (rows[i]) begin
      @(posedge sys_clk_i);
      start_dly_code_i <= rows[i].code;
      en_cmp_i <= 1'b1;
      wait_cyc(SS, 100, n);
      chk_n(n, rows[i].cyc);
      chk_b(deliver_o, 1'b1);
      @(posedge sys_clk_i);
      #1;
      chk_b(soft_start_o, 1'b0);
      wait_cyc(OKR, 100, n);
      wait_cyc(PGH, 100, n);
      chk_n(n, 11);
      @(posedge sys_clk_i);
      en_cmp_i <= 1'b0;
      wait_cyc(PGL, 100, n);
      chk_n(n, 3);
      chk_b(deliver_o, 1'b0);
      chk_b(cfg_rst_o, 1'b0);
      repeat (4) @(posedge sys_clk_i);
      $display("test startup code %0d done", i);
    end
    // bring up again with no delay for the hand-written cases
    @(posedge sys_clk_i);
    start_dly_code_i <= 3'h0;
    en_cmp_i <= 1'b1;
    wait_cyc(PGH, 100, n);
    // a 3-cycle dip is shorter than the de-glitch and must be ignored
    @(posedge sys_clk_i);
    dip <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    dip <= 1'b0;
    wait_cyc(PGL, 15, n);
    chk_n(n, 15);
    @(posedge sys_clk_i);
    dip <= 1'b1;
    wait_cyc(PGL, 50, n);
    chk_n(n, 9);
    $display("test deglitch done");
    // short good spell, then a one-cycle drop that must restart the delay
    @(posedge sys_clk_i);
    dip <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    dip <= 1'b1;
    @(posedge sys_clk_i);
    dip <= 1'b0;
    wait_cyc(PGH, 100, n);
    chk_n(n, 12);
    $display("test rise restart done");
    mod_step(1'b1, 1'b0);
    chk_b(hs_gate_o, 1'b0);
    chk_b(ls_gate_o, 1'b1);
    mod_step(1'b0, 1'b1);
    chk_b(hs_gate_o, 1'b1);
    chk_b(ls_gate_o, 1'b0);
    mod_step(1'b1, 1'b1);
    chk_b(hs_gate_o, 1'b0);
    $display("test modulator done");
    @(posedge sys_clk_i);
    therm_sd_i <= 1'b1;
    wait_cyc(PGL, 50, n);
    chk_n(n, 3);
    chk_b(deliver_o, 1'b0);
    chk_b(hs_gate_o | ls_gate_o, 1'b0);
    chk_b(cfg_rst_o, 1'b0);
    @(posedge sys_clk_i);
    therm_sd_i <= 1'b0;
    wait_cyc(PGH, 100, n);
    $display("test thermal done");
    // lockout while good: interface reset and indicator drop together
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk_b(cfg_rst_o, 1'b1);
    chk_b(ind_pin, 1'b0);
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk_b(cfg_rst_o, 1'b0);
    $display("test lockout done");
    test_done();
  end
endmodule
